/* core/frs_pkg.sv */
// Shared constants for the flash row sequencer and its controller
package frs_pkg;
    localparam int CLK_MHZ = 40;
    localparam int OP_TIME_US = 4000;
    localparam int OP_CYCLES_DFLT = OP_TIME_US * CLK_MHZ;
    localparam int FLASH_WORDS_DFLT = 1024;
    localparam int ROW_WORDS = 64;
    localparam int BLOCK_ROWS = 8;
    localparam int BLOCK_WORDS = ROW_WORDS * BLOCK_ROWS;
    localparam int ADDR_W = 24;
    localparam int WORD_W = 24;
    localparam int LOW_W = 16;
    localparam int HIGH_W = 8;
    localparam int SLOT_W = 6;
    localparam int ROWSEL_W = 3;
    localparam int ROW_LSB = 7;
    localparam int BLK_LSB = 10;
    localparam int OPSEL_W = 4;
    localparam int GO_BIT = 15;
    localparam int EN_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int ERASE_BIT = 6;
    localparam logic [3:0] OPSEL_PROG = 4'h1;
    localparam logic [3:0] OPSEL_ERASE = 4'h2;
    localparam logic [3:0] OPSEL_BULK = 4'hF;
    localparam logic [15:0] CW_ERASE = 16'h4042;
    localparam logic [15:0] CW_PROG = 16'h4001;
    localparam logic [15:0] CW_BULK = 16'h404F;
    localparam logic [15:0] GO_MASK = 16'h8000;
    localparam logic [15:0] KEY_FIRST = 16'h0055;
    localparam logic [15:0] KEY_SECOND = 16'h00AA;
    localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
    localparam logic [23:0] ROW_STEP = 24'h000080;
    localparam logic [23:0] INSTR_STEP = 24'h000002;
    localparam int NOP_SLOTS = 2;
    // Controller register map, byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_IDX = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_INT_STAT = 8'h14;
    localparam logic [7:0] REG_INT_CLR = 8'h18;
    localparam logic [7:0] REG_INT_EN = 8'h1C;
    localparam int CMD_GO_BIT = 8;
    localparam logic [1:0] CMD_ERASE = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_BULK = 2'h2;
    localparam int INT_DONE = 0;
    localparam int INT_FAULT = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {
        ST_CTRL = 2'b00,
        ST_KEY = 2'b01,
        ST_TBL_LO = 2'b10,
        ST_TBL_HI = 2'b11
    } frs_store_e;
endpackage

/* core/frs_if.sv */
// Store port between the processor-side controller and the flash sequencer
`timescale 1ns/100ps
interface frs_if;
    logic st_valid;
    frs_pkg::frs_store_e st_kind;
    logic [23:0] st_addr;
    logic [15:0] st_data;
    logic stall;
    logic [15:0] ctrl_word;
    modport dev (
        input st_valid,
        input st_kind,
        input st_addr,
        input st_data,
        output stall,
        output ctrl_word
    );
    modport core (
        output st_valid,
        output st_kind,
        output st_addr,
        output st_data,
        input stall,
        input ctrl_word
    );
endinterface

/* core/frs_dev.sv */
// Flash row program and block erase sequencer with holding buffer
`timescale 1ns/100ps
module frs_dev #(
    parameter int FLASH_WORDS = frs_pkg::FLASH_WORDS_DFLT,
    parameter int OP_CYCLES = frs_pkg::OP_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Processor store port
    frs_if.dev core,
    // Flash read port
    input wire logic [frs_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [frs_pkg::WORD_W-1:0] rd_data_o
);
    import frs_pkg::*;

    localparam int IDX_W = $clog2(FLASH_WORDS);
    localparam int ROWS = FLASH_WORDS / ROW_WORDS;
    localparam int CNT_W = $clog2(OP_CYCLES + 1);

    generate
        if (FLASH_WORDS != 2 ** IDX_W || FLASH_WORDS < 2 * BLOCK_WORDS || IDX_W >= ADDR_W)
        begin : g_bad_size
            $error("frs_dev: FLASH_WORDS must be a power of two, two blocks or more");
        end
        if (OP_CYCLES <= ROW_WORDS)
        begin : g_bad_time
            $error("frs_dev: OP_CYCLES must exceed the row length");
        end
    endgenerate

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } frs_key_e;

    typedef enum logic {
        OP_IDLE = 1'b0,
        OP_RUN = 1'b1
    } frs_op_e;

    logic go;
    logic next_go;
    logic wen;
    logic next_wen;
    logic fault;
    logic next_fault;
    logic erase;
    logic next_erase;
    logic [OPSEL_W-1:0] opsel;
    logic [OPSEL_W-1:0] next_opsel;
    frs_key_e key;
    frs_key_e next_key;
    frs_op_e op;
    frs_op_e next_op;
    logic prog;
    logic next_prog;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [ADDR_W-1:0] tgt;
    logic [ADDR_W-1:0] next_tgt;
    logic [ADDR_W-1:0] lo_addr;
    logic [ADDR_W-1:0] next_lo_addr;
    logic [LOW_W-1:0] lo_word;
    logic [LOW_W-1:0] next_lo_word;
    logic lo_pend;
    logic next_lo_pend;
    logic [ROWS-1:0] blank;
    logic [ROWS-1:0] next_blank;
    logic [WORD_W-1:0] next_rd;
    logic buf_we;
    logic mem_we;
    logic prog_req;
    logic erase_req;
    logic bulk_req;
    logic [IDX_W-ROW_LSB:0] tgt_row;
    logic [IDX_W-BLK_LSB:0] tgt_blk;
    logic [IDX_W-ROW_LSB:0] rd_row;
    // Holding buffer and array are plain memories, never reset
    logic [WORD_W-1:0] row_buf [ROW_WORDS];
    logic [WORD_W-1:0] mem [FLASH_WORDS];

    assign tgt_row = tgt[IDX_W:ROW_LSB];
    assign tgt_blk = tgt[IDX_W:BLK_LSB];
    assign rd_row = rd_addr_i[IDX_W:ROW_LSB];
    // Processor is held off for the whole self-timed cycle
    assign core.stall = (op == OP_RUN);
    assign core.ctrl_word = {go, wen, fault, 6'h00, erase, 2'b00, opsel};

    // Operation decode of the word being written, not the stored one
    assign prog_req = (core.st_data[OPSEL_W-1:0] == OPSEL_PROG) && !core.st_data[ERASE_BIT];
    assign erase_req = (core.st_data[OPSEL_W-1:0] == OPSEL_ERASE) && core.st_data[ERASE_BIT];
    assign bulk_req = (core.st_data[OPSEL_W-1:0] == OPSEL_BULK) && core.st_data[ERASE_BIT];

    always_comb
    begin
        next_go = go;
        next_wen = wen;
        next_fault = fault;
        next_erase = erase;
        next_opsel = opsel;
        next_key = key;
        next_op = op;
        next_prog = prog;
        next_cnt = cnt;
        next_tgt = tgt;
        next_lo_addr = lo_addr;
        next_lo_word = lo_word;
        next_lo_pend = lo_pend;
        next_blank = blank;
        buf_we = 1'b0;
        mem_we = 1'b0;
        next_rd = blank[rd_row] ? ERASED_WORD : mem[rd_addr_i[IDX_W:1]];
        if (op == OP_RUN)
        begin
            next_cnt = cnt + 1'b1;
            // Row copy spreads over the first cycles of the timed window
            mem_we = prog && (cnt < CNT_W'(ROW_WORDS));
            if (cnt == CNT_W'(OP_CYCLES - 1))
            begin
                next_op = OP_IDLE;
                next_go = 1'b0;
                next_cnt = '0;
            end
        end
        else if (core.st_valid)
        begin
            // Any store breaks the key pair unless it continues it
            next_key = KEY_IDLE;
            unique case (core.st_kind)
                ST_KEY:
                begin
                    if (core.st_data == KEY_FIRST)
                    begin
                        next_key = KEY_HALF;
                    end
                    else if (key == KEY_HALF && core.st_data == KEY_SECOND)
                    begin
                        next_key = KEY_OPEN;
                    end
                end
                ST_TBL_LO:
                begin
                    next_lo_pend = 1'b1;
                    next_lo_addr = core.st_addr;
                    next_lo_word = core.st_data;
                    next_tgt = core.st_addr;
                end
                ST_TBL_HI:
                begin
                    // A high byte without its low word is dropped
                    buf_we = lo_pend && (core.st_addr == lo_addr);
                    next_lo_pend = 1'b0;
                end
                ST_CTRL:
                begin
                    next_wen = core.st_data[EN_BIT];
                    next_fault = core.st_data[FAULT_BIT];
                    next_erase = core.st_data[ERASE_BIT];
                    next_opsel = core.st_data[OPSEL_W-1:0];
                    if (core.st_data[GO_BIT])
                    begin
                        if (key != KEY_OPEN || !core.st_data[EN_BIT])
                        begin
                            next_fault = 1'b1;
                        end
                        else if (prog_req)
                        begin
                            if (!blank[tgt_row])
                            begin
                                next_fault = 1'b1;
                            end
                            else
                            begin
                                next_op = OP_RUN;
                                next_go = 1'b1;
                                next_prog = 1'b1;
                                next_blank[tgt_row] = 1'b0;
                            end
                        end
                        else if (erase_req || bulk_req)
                        begin
                            next_op = OP_RUN;
                            next_go = 1'b1;
                            next_prog = 1'b0;
                            if (bulk_req)
                            begin
                                next_blank = '1;
                            end
                            else
                            begin
                                for (int i = 0; i < BLOCK_ROWS; i++)
                                begin
                                    next_blank[{tgt_blk, ROWSEL_W'(i)}] = 1'b1;
                                end
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            go <= 1'b0;
            wen <= 1'b0;
            fault <= 1'b0;
            erase <= 1'b0;
            opsel <= '0;
            key <= KEY_IDLE;
            op <= OP_IDLE;
            prog <= 1'b0;
            cnt <= '0;
            tgt <= '0;
            lo_addr <= '0;
            lo_word <= '0;
            lo_pend <= 1'b0;
            blank <= '1;
            rd_data_o <= '0;
        end
        else
        begin
            go <= next_go;
            wen <= next_wen;
            fault <= next_fault;
            erase <= next_erase;
            opsel <= next_opsel;
            key <= next_key;
            op <= next_op;
            prog <= next_prog;
            cnt <= next_cnt;
            tgt <= next_tgt;
            lo_addr <= next_lo_addr;
            lo_word <= next_lo_word;
            lo_pend <= next_lo_pend;
            blank <= next_blank;
            rd_data_o <= next_rd;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (buf_we)
        begin
            row_buf[core.st_addr[ROW_LSB-1:1]] <= {core.st_data[HIGH_W-1:0], lo_word};
        end
        if (mem_we)
        begin
            mem[{tgt_row, cnt[SLOT_W-1:0]}] <= row_buf[cnt[SLOT_W-1:0]];
        end
    end
endmodule

/* core/frs_ctl.sv */
// Processor-side controller: AHB-Lite registers drive the flash store sequence
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module frs_ctl (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Interrupt
    output logic irq_o,
    // Flash store port
    frs_if.core flash
);
    import frs_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_CTRL = 4'b0001,
        H_ADDR = 4'b0010,
        H_LOAD_LO = 4'b0011,
        H_LOAD_HI = 4'b0100,
        H_KEY1 = 4'b0101,
        H_KEY2 = 4'b0110,
        H_GO = 4'b0111,
        H_NOP = 4'b1000,
        H_WAIT = 4'b1001
    } frs_host_e;

    frs_host_e st;
    frs_host_e next_st;
    logic [1:0] opc;
    logic [1:0] next_opc;
    logic [23:0] addr;
    logic [23:0] next_addr;
    logic [SLOT_W-1:0] idx;
    logic [SLOT_W-1:0] next_idx;
    logic [SLOT_W-1:0] cnt;
    logic [SLOT_W-1:0] next_cnt;
    logic [1:0] int_stat;
    logic [1:0] next_int_stat;
    logic [1:0] int_en;
    logic [1:0] next_int_en;
    logic [15:0] cw;
    logic [15:0] next_cw;
    logic dp_wr;
    logic next_dp_wr;
    logic [7:0] dp_addr;
    logic [7:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic s_valid;
    frs_store_e s_kind;
    logic [23:0] s_addr;
    logic [15:0] s_data;
    logic ram_we;
    logic [WORD_W-1:0] ram [ROW_WORDS];

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign irq_o = |(int_stat & int_en);

    always_comb
    begin
        next_st = st;
        next_opc = opc;
        next_addr = addr;
        next_idx = idx;
        next_cnt = cnt;
        next_int_stat = int_stat;
        next_int_en = int_en;
        next_cw = cw;
        next_hrdata = hrdata_o;
        ram_we = 1'b0;
        s_valid = 1'b0;
        s_kind = ST_CTRL;
        s_addr = addr;
        s_data = '0;
        // Zero-wait slave: address phase latched, write applied in data phase
        next_dp_wr = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && hwrite_i;
        next_dp_addr = haddr_i[7:0];
        if (hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i)
        begin
            unique case (haddr_i[7:0])
                REG_CMD: next_hrdata = {23'h0, st != H_IDLE, 6'h00, opc};
                REG_ADDR: next_hrdata = {8'h00, addr};
                REG_IDX: next_hrdata = {26'h0, idx};
                REG_STAT: next_hrdata = {16'h0000, flash.ctrl_word};
                REG_INT_STAT: next_hrdata = {30'h0, int_stat};
                REG_INT_EN: next_hrdata = {30'h0, int_en};
                default: next_hrdata = 32'h00000000;
            endcase
        end
        if (dp_wr)
        begin
            unique case (dp_addr)
                REG_CMD:
                begin
                    // Commands while a sequence runs are ignored
                    if (st == H_IDLE)
                    begin
                        next_opc = hwdata_i[1:0];
                        if (hwdata_i[CMD_GO_BIT])
                        begin
                            next_st = H_CTRL;
                        end
                    end
                end
                REG_ADDR: next_addr = (st == H_IDLE) ? hwdata_i[23:0] : addr;
                REG_IDX: next_idx = hwdata_i[SLOT_W-1:0];
                REG_DATA:
                begin
                    ram_we = 1'b1;
                    next_idx = idx + 1'b1;
                end
                REG_INT_CLR: next_int_stat = int_stat & ~hwdata_i[1:0];
                REG_INT_EN: next_int_en = hwdata_i[1:0];
                default: next_int_en = int_en;
            endcase
        end
        unique case (st)
            H_IDLE: s_valid = 1'b0;
            H_CTRL:
            begin
                s_valid = 1'b1;
                s_kind = ST_CTRL;
                if (opc == CMD_PROG)
                begin
                    next_cw = CW_PROG;
                    next_st = H_LOAD_LO;
                end
                else
                begin
                    next_cw = (opc == CMD_BULK) ? CW_BULK : CW_ERASE;
                    next_st = H_ADDR;
                end
                next_cnt = '0;
                s_data = next_cw;
            end
            H_ADDR:
            begin
                s_valid = 1'b1;
                s_kind = ST_TBL_LO;
                s_data = addr[15:0];
                next_st = H_KEY1;
            end
            H_LOAD_LO, H_LOAD_HI:
            begin
                s_valid = 1'b1;
                s_addr = addr + {17'h0, cnt, 1'b0};
                if (st == H_LOAD_LO)
                begin
                    s_kind = ST_TBL_LO;
                    s_data = ram[cnt][LOW_W-1:0];
                    next_st = H_LOAD_HI;
                end
                else
                begin
                    s_kind = ST_TBL_HI;
                    s_data = {8'h00, ram[cnt][WORD_W-1:LOW_W]};
                    next_cnt = cnt + 1'b1;
                    next_st = (cnt == SLOT_W'(ROW_WORDS - 1)) ? H_KEY1 : H_LOAD_LO;
                end
            end
            H_KEY1, H_KEY2:
            begin
                // Keys and go leave back to back, nothing can slip between
                s_valid = 1'b1;
                s_kind = ST_KEY;
                s_data = (st == H_KEY1) ? KEY_FIRST : KEY_SECOND;
                next_st = (st == H_KEY1) ? H_KEY2 : H_GO;
            end
            H_GO:
            begin
                s_valid = 1'b1;
                s_kind = ST_CTRL;
                s_data = cw | GO_MASK;
                next_cnt = '0;
                next_st = H_NOP;
            end
            H_NOP:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == SLOT_W'(NOP_SLOTS - 1))
                begin
                    next_st = H_WAIT;
                end
            end
            H_WAIT:
            begin
                if (!flash.stall && !flash.ctrl_word[GO_BIT])
                begin
                    next_st = H_IDLE;
                    next_int_stat[INT_DONE] = 1'b1;
                    if (flash.ctrl_word[FAULT_BIT])
                    begin
                        next_int_stat[INT_FAULT] = 1'b1;
                    end
                    else if (opc == CMD_PROG)
                    begin
                        next_addr = addr + ROW_STEP;
                    end
                end
            end
            default: next_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            st <= H_IDLE;
            opc <= CMD_ERASE;
            addr <= '0;
            idx <= '0;
            cnt <= '0;
            int_stat <= '0;
            int_en <= '0;
            cw <= '0;
            dp_wr <= 1'b0;
            dp_addr <= '0;
            hrdata_o <= '0;
            flash.st_valid <= 1'b0;
            flash.st_kind <= ST_CTRL;
            flash.st_addr <= '0;
            flash.st_data <= '0;
        end
        else
        begin
            st <= next_st;
            opc <= next_opc;
            addr <= next_addr;
            idx <= next_idx;
            cnt <= next_cnt;
            int_stat <= next_int_stat;
            int_en <= next_int_en;
            cw <= next_cw;
            dp_wr <= next_dp_wr;
            dp_addr <= next_dp_addr;
            hrdata_o <= next_hrdata;
            flash.st_valid <= s_valid;
            flash.st_kind <= s_kind;
            flash.st_addr <= s_addr;
            flash.st_data <= s_data;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (ram_we)
        begin
            ram[idx] <= hwdata_i[WORD_W-1:0];
        end
    end
endmodule

/* bench/frs_chk.sv */
// Assertions on the store link between controller and sequencer
`timescale 1ns/100ps
module frs_chk
    import frs_pkg::*;
#(
    parameter int OP_CYCLES = OP_CYCLES_DFLT
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic st_valid,
    input frs_pkg::frs_store_e st_kind,
    input wire logic [23:0] st_addr,
    input wire logic [15:0] st_data,
    input wire logic stall,
    input wire logic [15:0] ctrl_word
);
    // Wide enough for the full-length default cycle, not only the short bench one
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    always_comb next_cnt = stall ? cnt + 32'h00000001 : 32'h00000000;
    always_ff @(posedge clock_i) cnt <= rst_n_i ? next_cnt : 32'h00000000;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_stall_go: assert property (stall |-> ctrl_word[15])
        else $error("stall without go bit");
    a_go_stalls: assert property ($rose(ctrl_word[15]) |-> stall && ctrl_word[14])
        else $error("go rose without enable or stall");
    a_go_keys: assert property ($rose(ctrl_word[15]) |->
        $past(st_data, 2) == KEY_SECOND && $past(st_data, 3) == KEY_FIRST)
        else $error("go without key pair");
    a_op_code: assert property ($rose(ctrl_word[15]) |->
        ctrl_word[6:0] inside {7'h42, 7'h01, 7'h4F})
        else $error("go with undefined operation");
    a_op_length: assert property ($fell(stall) |-> cnt == 32'(OP_CYCLES))
        else $error("operation length wrong");
    a_go_clears: assert property ($fell(stall) |-> !ctrl_word[15])
        else $error("go not cleared at end");
    a_quiet_stall: assert property (stall |-> !st_valid)
        else $error("store during stall");
    a_high_pair: assert property (st_valid && st_kind == ST_TBL_HI |->
        $past(st_valid) && $past(st_kind) == ST_TBL_LO && $past(st_addr) == st_addr)
        else $error("high byte store not paired");
    c_erase: cover property ($rose(ctrl_word[15]) && ctrl_word[6:0] == 7'h42);
    c_prog: cover property ($rose(ctrl_word[15]) && ctrl_word[6:0] == 7'h01);
    c_bulk: cover property ($rose(ctrl_word[15]) && ctrl_word[6:0] == 7'h4F);
endmodule

/* bench/frs_tb.sv */
// Testbench: controller and sequencer joined, plus a rule-breaking link
`timescale 1ns/100ps
module flash_row_program_erase_sequencer_tb;
    import frs_pkg::*;
    logic clk;
    logic rst_n = 0;
    logic hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic [23:0] rd_addr = 0;
    logic [23:0] rd_data;
    logic [31:0] r;
    logic [23:0] mdl[$];
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    frs_if fi ();
    frs_if fb ();
    frs_ctl frs_ctl_i (.clock_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .irq_o(irq), .flash(fi.core));
    frs_dev #(.OP_CYCLES(200)) frs_dev_i (.clock_i(clk), .rst_n_i(rst_n), .core(fi.dev),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data));
    frs_dev #(.OP_CYCLES(200)) frs_dev_bad_i (.clock_i(clk), .rst_n_i(rst_n),
        .core(fb.dev), .rd_addr_i(rd_addr), .rd_data_o());
    frs_chk #(.OP_CYCLES(200)) frs_chk_i (.clock_i(clk), .rst_n_i(rst_n),
        .st_valid(fi.st_valid), .st_kind(fi.st_kind), .st_addr(fi.st_addr),
        .st_data(fi.st_data), .stall(fi.stall), .ctrl_word(fi.ctrl_word));
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // Busy covers the whole store sequence and the self-timed cycle
    task automatic run(input logic [1:0] op);
        ahb(1, REG_CMD, {23'h0, 1'b1, 6'h0, op});
        do ahb(0, REG_CMD, 0); while (r[8] !== 1'b0);
    endtask
    task automatic fl(input logic [23:0] a, input logic [23:0] e);
        @(posedge clk);
        rd_addr <= a;
        repeat (2) @(posedge clk);
        chk("flash word", {8'h0, rd_data}, {8'h0, e});
    endtask
    task automatic bst(input frs_store_e k, input logic [15:0] d);
        @(posedge clk);
        fb.st_valid <= 1;
        fb.st_kind <= k;
        fb.st_data <= d;
    endtask
    task automatic bend(input logic f);
        @(posedge clk);
        fb.st_valid <= 0;
        fb.st_data <= ~fb.st_data;
        repeat (2) @(posedge clk);
        chk("bad link fault", fb.ctrl_word[FAULT_BIT], f);
        chk("bad link stall", fb.stall, 0);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        fb.st_valid = 0;
        fb.st_kind = ST_CTRL;
        fb.st_addr = 0;
        fb.st_data = 0;
        void'($urandom(64988));
        repeat (3) @(posedge clk);
        rst_n <= 1;
        ahb(0, REG_STAT, 0);
        chk("status", r, 0);
        ahb(0, 8'h20, 0);
        chk("unmapped", r, 0);
        chk("okay response", hresp, 0);
        ahb(1, REG_INT_EN, 3);
        ahb(1, REG_ADDR, 0);
        run(CMD_ERASE);
        ahb(0, REG_STAT, 0);
        chk("control word", r, {16'h0, CW_ERASE});
        ahb(0, REG_INT_STAT, 0);
        chk("done", r, 1);
        chk("irq", irq, 1);
        ahb(1, REG_INT_EN, 0);
        ahb(0, REG_INT_STAT, 0);
        chk("irq masked", irq, 0);
        ahb(1, REG_INT_CLR, 3);
        ahb(1, REG_INT_EN, 3);
        ahb(0, REG_INT_STAT, 0);
        chk("cleared", r, 0);
        ahb(1, REG_IDX, 0);
        for (int k = 0; k < ROW_WORDS; k++)
        begin
            mdl.push_back(24'($urandom));
            ahb(1, REG_DATA, {8'h0, mdl[k]});
        end
        run(CMD_PROG);
        ahb(0, REG_ADDR, 0);
        chk("next row", r, 32'h80);
        for (int k = 0; k < ROW_WORDS; k++)
            fl(24'(2 * k), mdl[k]);
        fl(ROW_STEP, ERASED_WORD);
        ahb(1, REG_ADDR, 0);
        ahb(1, REG_INT_CLR, 3);
        run(CMD_PROG);
        ahb(0, REG_INT_STAT, 0);
        chk("overwrite fault", r, 3);
        ahb(0, REG_ADDR, 0);
        chk("row kept", r, 0);
        fl(0, mdl[0]);
        run(CMD_BULK);
        fl(0, ERASED_WORD);
        // Link with a stray store between the keys, then with enable clear
        bst(ST_KEY, KEY_FIRST);
        bst(ST_CTRL, CW_ERASE);
        bst(ST_KEY, KEY_SECOND);
        bst(ST_CTRL, CW_ERASE | GO_MASK);
        bend(1);
        bst(ST_CTRL, 16'h0042);
        bst(ST_KEY, KEY_FIRST);
        bst(ST_KEY, KEY_SECOND);
        bst(ST_CTRL, 16'h8042);
        bend(1);
        // Erase code without the erase bit: unlocked go must do nothing, no fault
        bst(ST_KEY, KEY_FIRST);
        bst(ST_KEY, KEY_SECOND);
        bst(ST_CTRL, (CW_ERASE & 16'hFFBF) | GO_MASK);
        bend(0);
        end_of_test();
    end
endmodule
